// ===== src/nvm_pkg.sv
// Purpose: Shared constants and types for the NVM control block
// Assumes: 20 MHz system clock, APB register access
// Notes: Times are kept in microseconds, cycle counts derive from them
package nvm_pkg;
    // Clock
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Array geometry
    localparam int unsigned ADDR_W = 15;
    localparam int unsigned WORD_W = 14;
    localparam int unsigned FLASH_WORDS = 8192;
    localparam int unsigned ROW_WORDS = 32;
    localparam int unsigned EE_BYTES = 256;
    localparam logic [14:0] ID_ADDR = 15'h0106;
    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam int unsigned PADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_UNLOCK = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_DLO = 8'h0C;
    localparam logic [7:0] OFF_DHI = 8'h10;
    localparam logic [7:0] OFF_ISTAT = 8'h14;
    localparam logic [7:0] OFF_ICLR = 8'h18;
    localparam logic [7:0] OFF_IEN = 8'h1C;
    // Control register fields
    localparam int unsigned BIT_SPACE = 6;
    localparam int unsigned BIT_LATCH = 5;
    localparam int unsigned BIT_ERASE = 4;
    localparam int unsigned BIT_ERR = 3;
    localparam int unsigned BIT_PEN = 2;
    localparam int unsigned BIT_WR = 1;
    localparam int unsigned BIT_RD = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Interrupt status fields
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_ERR = 1;
    // Unlock keys
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    ////////////////////////////////////////////////////////////////////////
    // Self-timed operation lengths
    localparam int unsigned TMR_W = 17;
    localparam int unsigned PROG_TIME_US = 2000;
    localparam int unsigned ERASE_TIME_US = 2000;
    localparam int unsigned EE_TIME_US = 4000;
    localparam int unsigned PROG_CYCLES =
        (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ERASE_CYCLES =
        (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EE_CYCLES =
        (EE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [16:0] LATCH_CYCLES = 17'h00001;
    ////////////////////////////////////////////////////////////////////////
    // States and operation kinds
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_LOAD = 2'b10,
        ST_BUSY = 2'b11
    } ctl_state_t;
    typedef enum logic [1:0] {
        OP_LATCH = 2'b00,
        OP_PROG = 2'b01,
        OP_ERASE = 2'b10,
        OP_EE = 2'b11
    } op_t;
    typedef enum logic [1:0] {
        UL_NONE = 2'b00,
        UL_HALF = 2'b01,
        UL_ARMED = 2'b10
    } unlock_t;
    // Data space address that lands in the EEPROM
    function automatic logic in_eeprom(input logic space,
                                       input logic [14:0] addr);
        in_eeprom = space && (addr < 15'(EE_BYTES));
    endfunction
endpackage

// ===== src/nvm_unlock.sv
// Purpose: Two-key unlock sequence tracker
// Assumes: key_we pulses once per write to the unlock register
// Notes: Any wrong key restarts the sequence
`timescale 1ns/1ns
`default_nettype none
module nvm_unlock (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // Key writes and consume
    input wire logic key_we,
    input wire logic [7:0] key_data,
    input wire logic consume,
    // Status
    output logic armed
);
    import nvm_pkg::*;
    unlock_t stage_reg, stage_next;

    // Sequence tracking, consumed by any start attempt
    always_comb begin
        stage_next = stage_reg;
        if (consume) begin
            stage_next = UL_NONE;
        end else if (key_we) begin
            case (stage_reg)
                UL_NONE: stage_next = (key_data == KEY_FIRST) ?
                                      UL_HALF : UL_NONE;
                UL_HALF: stage_next = (key_data == KEY_SECOND) ?
                                      UL_ARMED : UL_NONE;
                default: stage_next = UL_NONE;
            endcase
        end
    end

    // Stage register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage_reg <= UL_NONE;
        end else if (clk_en) begin
            stage_reg <= stage_next;
        end
    end

    assign armed = (stage_reg == UL_ARMED);
endmodule
`default_nettype wire

// ===== src/nvm_store.sv
// Purpose: Flash array, EEPROM, row write latches and read port
// Assumes: Commands are one-cycle pulses, address stable meanwhile
// Notes: Array contents are not reset, as in a real nonvolatile part
`timescale 1ns/1ns
`default_nettype none
module nvm_store #(
    parameter logic [13:0] DEVICE_ID = 14'h1234 // Arbitrary value
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // Address and data
    input wire logic space,
    input wire logic [14:0] addr,
    input wire logic [7:0] wdata_lo,
    input wire logic [5:0] wdata_hi,
    // Commands
    input wire logic rd_req,
    input wire logic latch_we,
    input wire logic row_prog,
    input wire logic row_erase,
    input wire logic ee_we,
    // Read data
    output logic [7:0] rdata_lo,
    output logic [5:0] rdata_hi
);
    import nvm_pkg::*;
    logic [13:0] flash_mem [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [13:0] latch_mem [ROW_WORDS];
    logic [31:0] lvalid_reg, lvalid_next;
    logic [13:0] rword_reg, rword_next;

    // Read mux and latch valid bookkeeping
    always_comb begin
        rword_next = rword_reg;
        lvalid_next = lvalid_reg;
        if (rd_req) begin
            if (!space) begin
                rword_next = flash_mem[addr[12:0]];
            end else if (in_eeprom(space, addr)) begin
                rword_next = {6'h00, ee_mem[addr[7:0]]};
            end else if (addr == ID_ADDR) begin
                rword_next = DEVICE_ID;
            end else begin
                rword_next = 14'h0000;
            end
        end
        if (latch_we) begin
            lvalid_next[addr[4:0]] = 1'b1;
        end
        if (row_prog) begin
            lvalid_next = 32'h00000000;
        end
    end

    // Registered state
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rword_reg <= 14'h0000;
            lvalid_reg <= 32'h00000000;
        end else if (clk_en) begin
            rword_reg <= rword_next;
            lvalid_reg <= lvalid_next;
        end
    end

    // Memory arrays, row wide program and erase
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (latch_we) begin
                latch_mem[addr[4:0]] <= {wdata_hi, wdata_lo};
            end
            for (int i = 0; i < ROW_WORDS; i++) begin
                if (row_prog && lvalid_reg[i]) begin
                    flash_mem[{addr[12:5], 5'(i)}] <= latch_mem[i];
                end
                if (row_erase) begin
                    flash_mem[{addr[12:5], 5'(i)}] <= 14'h3FFF;
                end
            end
            if (ee_we) begin
                ee_mem[addr[7:0]] <= wdata_lo;
            end
        end
    end

    assign rdata_lo = rword_reg[7:0];
    assign rdata_hi = rword_reg[13:8];
endmodule
`default_nettype wire

// ===== src/nvm_program_erase_control.sv
// Purpose: NVM read, latch load, row program and row erase control
// Assumes: APB3 slave, single 20 MHz clock, synchronous inputs
// Notes: Array operations are self-timed and committed at the end
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - space select picks data space or flash
// - latch-only write just loads word latch
// - latch clear commits; erase ignores latch-only
// - flash erase clears 32-word row to ones
// - hardware clears erase select when done
// - read start loads data, then self-clears
// - software can only set read start
// - EEPROM read loads low byte only
module nvm_program_erase_control #(
    parameter int unsigned PROG_CYCLES = nvm_pkg::PROG_CYCLES,
    parameter int unsigned ERASE_CYCLES = nvm_pkg::ERASE_CYCLES,
    parameter int unsigned EE_CYCLES = nvm_pkg::EE_CYCLES,
    parameter logic [14:0] WP_LIMIT = 15'h0000,
    parameter logic [13:0] DEVICE_ID = 14'h1234 // Arbitrary value
) (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic warm_reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nvm_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq
);
    import nvm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    ctl_state_t state_reg, state_next;
    op_t op_reg, op_next;
    logic [TMR_W-1:0] tmr_reg, tmr_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [14:0] addr_reg, addr_next;
    logic [7:0] dlo_reg, dlo_next;
    logic [5:0] dhi_reg, dhi_next;
    logic [1:0] istat_reg, istat_next;
    logic [1:0] ien_reg, ien_next;
    logic irq_reg, irq_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    // Strobes toward the submodules
    logic rd_req, latch_we, row_prog, row_erase, ee_we;
    logic key_we, consume, armed, err_set, done_set;
    logic [7:0] st_lo;
    logic [5:0] st_hi;
    logic access, wr_fire, mapped, idle;
    logic [7:0] wv;

    // Address decode helper
    function automatic logic hit(input logic [PADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Write protection: config area or low flash below the limit
    function automatic logic is_protected(input logic space,
                                          input logic [14:0] a);
        is_protected = space ? !in_eeprom(space, a) : (a < WP_LIMIT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus qualifiers
    assign access = psel && penable;
    assign wr_fire = access && pready_reg && pwrite;
    assign idle = (state_reg == ST_IDLE);
    assign wv = pwdata[7:0];
    assign mapped = hit(paddr, OFF_CTRL) || hit(paddr, OFF_UNLOCK) ||
                    hit(paddr, OFF_ADDR) || hit(paddr, OFF_DLO) ||
                    hit(paddr, OFF_DHI) || hit(paddr, OFF_ISTAT) ||
                    hit(paddr, OFF_ICLR) || hit(paddr, OFF_IEN);
    assign key_we = wr_fire && idle && hit(paddr, OFF_UNLOCK);
    assign rd_req = (state_reg == ST_READ);

    // APB answer one cycle into the access phase
    always_comb begin
        pready_next = access && !pready_reg;
        pslverr_next = access && !pready_reg && !mapped;
        prdata_next = prdata_reg;
        if (access && !pready_reg && !pwrite) begin
            prdata_next = 32'h00000000;
            if (hit(paddr, OFF_CTRL)) begin
                prdata_next[7:0] = ctrl_reg;
            end else if (hit(paddr, OFF_ADDR)) begin
                prdata_next[14:0] = addr_reg;
            end else if (hit(paddr, OFF_DLO)) begin
                prdata_next[7:0] = dlo_reg;
            end else if (hit(paddr, OFF_DHI)) begin
                prdata_next[5:0] = dhi_reg;
            end else if (hit(paddr, OFF_ISTAT)) begin
                prdata_next[1:0] = istat_reg;
            end else if (hit(paddr, OFF_IEN)) begin
                prdata_next[1:0] = ien_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control sequencing and register writes
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        tmr_next = tmr_reg;
        ctrl_next = ctrl_reg;
        addr_next = addr_reg;
        dlo_next = dlo_reg;
        dhi_next = dhi_reg;
        ien_next = ien_reg;
        consume = 1'b0;
        latch_we = 1'b0;
        row_prog = 1'b0;
        row_erase = 1'b0;
        ee_we = 1'b0;
        err_set = 1'b0;
        done_set = 1'b0;
        // Operation progress
        case (state_reg)
            ST_IDLE: begin
                state_next = ST_IDLE;
            end
            ST_READ: begin
                state_next = ST_LOAD;
            end
            ST_LOAD: begin
                dlo_next = st_lo;
                if (!in_eeprom(ctrl_reg[BIT_SPACE], addr_reg)) begin
                    dhi_next = st_hi;
                end
                ctrl_next[BIT_RD] = 1'b0;
                state_next = ST_IDLE;
            end
            ST_BUSY: begin
                if (tmr_reg <= LATCH_CYCLES) begin
                    case (op_reg)
                        OP_PROG: row_prog = 1'b1;
                        OP_ERASE: begin
                            row_erase = 1'b1;
                            ctrl_next[BIT_ERASE] = 1'b0;
                        end
                        OP_EE: ee_we = 1'b1;
                        default: ee_we = 1'b0;
                    endcase
                    ctrl_next[BIT_WR] = 1'b0;
                    done_set = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    tmr_next = tmr_reg - LATCH_CYCLES;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Register writes, most are held off while busy
        if (wr_fire && hit(paddr, OFF_CTRL)) begin
            ctrl_next[BIT_ERR] = wv[BIT_ERR];
            if (idle) begin
                ctrl_next[BIT_SPACE] = wv[BIT_SPACE];
                ctrl_next[BIT_LATCH] = wv[BIT_LATCH];
                ctrl_next[BIT_ERASE] = wv[BIT_ERASE];
                ctrl_next[BIT_PEN] = wv[BIT_PEN];
                if (wv[BIT_WR]) begin
                    consume = 1'b1;
                    if (!armed) begin
                        err_set = 1'b1;
                    end else if (!wv[BIT_PEN]) begin
                        err_set = 1'b0;
                    end else if (is_protected(wv[BIT_SPACE], addr_reg)) begin
                        err_set = 1'b1;
                    end else begin
                        ctrl_next[BIT_WR] = 1'b1;
                        state_next = ST_BUSY;
                        if (wv[BIT_SPACE]) begin
                            op_next = OP_EE;
                            tmr_next = TMR_W'(EE_CYCLES);
                        end else if (wv[BIT_ERASE]) begin
                            op_next = OP_ERASE;
                            tmr_next = TMR_W'(ERASE_CYCLES);
                        end else if (wv[BIT_LATCH]) begin
                            op_next = OP_LATCH;
                            latch_we = 1'b1;
                            tmr_next = LATCH_CYCLES;
                        end else begin
                            op_next = OP_PROG;
                            latch_we = 1'b1;
                            tmr_next = TMR_W'(PROG_CYCLES);
                        end
                    end
                end else if (wv[BIT_RD]) begin
                    ctrl_next[BIT_RD] = 1'b1;
                    state_next = ST_READ;
                end
            end
        end
        if (wr_fire && idle && hit(paddr, OFF_ADDR)) begin
            addr_next = pwdata[14:0];
        end
        if (wr_fire && idle && hit(paddr, OFF_DLO)) begin
            dlo_next = wv;
        end
        if (wr_fire && idle && hit(paddr, OFF_DHI)) begin
            dhi_next = pwdata[5:0];
        end
        if (wr_fire && hit(paddr, OFF_IEN)) begin
            ien_next = pwdata[1:0];
        end
        // Warm reset aborts any operation in flight
        if (warm_reset) begin
            consume = 1'b1;
            err_set = (state_reg == ST_BUSY);
            done_set = 1'b0;
            row_prog = 1'b0;
            row_erase = 1'b0;
            ee_we = 1'b0;
            latch_we = 1'b0;
            ctrl_next[BIT_WR] = 1'b0;
            ctrl_next[BIT_RD] = 1'b0;
            state_next = ST_IDLE;
        end
        // Hardware set wins over a software clear
        if (err_set) begin
            ctrl_next[BIT_ERR] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, clear and enable
    always_comb begin
        istat_next = istat_reg;
        if (wr_fire && hit(paddr, OFF_ICLR)) begin
            istat_next = istat_reg & ~pwdata[1:0];
        end
        if (done_set) begin
            istat_next[IRQ_DONE] = 1'b1;
        end
        if (err_set) begin
            istat_next[IRQ_ERR] = 1'b1;
        end
        irq_next = |(istat_next & ien_next);
    end

    // Registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_LATCH;
            tmr_reg <= '0;
            ctrl_reg <= CTRL_RST;
            addr_reg <= 15'h0000;
            dlo_reg <= 8'h00;
            dhi_reg <= 6'h00;
            istat_reg <= 2'h0;
            ien_reg <= 2'h0;
            irq_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            op_reg <= op_next;
            tmr_reg <= tmr_next;
            ctrl_reg <= ctrl_next;
            addr_reg <= addr_next;
            dlo_reg <= dlo_next;
            dhi_reg <= dhi_next;
            istat_reg <= istat_next;
            ien_reg <= ien_next;
            irq_reg <= irq_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    nvm_unlock u_unlock (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .key_we(key_we),
        .key_data(wv),
        .consume(consume),
        .armed(armed)
    );

    nvm_store #(
        .DEVICE_ID(DEVICE_ID)
    ) u_store (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .space(ctrl_reg[BIT_SPACE]),
        .addr(addr_reg),
        .wdata_lo(dlo_reg),
        .wdata_hi(dhi_reg),
        .rd_req(rd_req),
        .latch_we(latch_we),
        .row_prog(row_prog),
        .row_erase(row_erase),
        .ee_we(ee_we),
        .rdata_lo(st_lo),
        .rdata_hi(st_hi)
    );

    // Outputs straight from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

// ===== testbench/nvm_program_erase_control_chk.sv
// Purpose: Port-level checks of the NVM control block
// Assumes: clk_en held high, one clock domain
// Notes: Bound from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module nvm_program_erase_control_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nvm_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt
    input wire logic irq
);
    import nvm_pkg::*;
    logic acc;
    logic rd_done;
    ////////////////////////////////////////////////////////////////////////
    // Access phase still waiting, and completed reads
    assign acc = psel && penable && !pready;
    assign rd_done = pready && !pwrite;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    // Bus timing
    chk_wait_one: assert property (acc |=> pready)
        else $error("pready not after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_ready_cause: assert property (pready |-> $past(acc))
        else $error("pready without access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_err: assert property (acc && paddr > 8'h1C |=> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (
        acc && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    // Read data widths and write-only places
    chk_ctrl_top: assert property (
        rd_done && paddr == OFF_CTRL |-> prdata[31:7] == 25'h0)
        else $error("control upper bits not zero");
    chk_high_width: assert property (
        rd_done && paddr == OFF_DHI |-> prdata[31:6] == 26'h0)
        else $error("high data upper bits not zero");
    chk_wo_zero: assert property (rd_done
        && (paddr == OFF_UNLOCK || paddr == OFF_ICLR) |-> prdata == 32'h0)
        else $error("write-only register read not zero");
    // Interrupt follows its enable
    chk_irq_off: assert property (pready && pwrite && paddr == OFF_IEN
        && pwdata[1:0] == 2'h0 |-> ##2 !irq)
        else $error("irq high with all enables off");
endmodule
`default_nettype wire

// ===== testbench/test_nvm_program_erase_control.sv
// Purpose: Self-checking bench for the NVM control block
// Assumes: Short self-timed lengths, clk_en held high
// Notes: Seeded random data mixed with fixed corner cases
`timescale 1ns/1ns
`default_nettype none
module test_nvm_program_erase_control;
    import nvm_pkg::*;
    localparam int unsigned OP_LEN = 4;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic warm_reset = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] rdv;
    logic errv;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [13:0] row_exp [32];
    logic [14:0] base;
    logic [7:0] ee_a;
    logic [7:0] ee_d;
    int miscompares = 0;
    int compares = 0;
    ////////////////////////////////////////////////////////////////////////
    // Design and clock
    nvm_program_erase_control #(.PROG_CYCLES(OP_LEN),
        .ERASE_CYCLES(OP_LEN), .EE_CYCLES(OP_LEN))
    nvm_program_erase_control_i (.clock(clock), .nrst(nrst), .clk_en(1'b1),
        .warm_reset(warm_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    always #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    // Compare and closing tasks
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One APB transfer and an idle edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic unlock();
        wr(OFF_UNLOCK, 32'(KEY_FIRST));
        wr(OFF_UNLOCK, 32'(KEY_SECOND));
    endtask
    task automatic wait_idle();
        int n = 0;
        do begin
            rd(OFF_CTRL);
            n++;
        end while (rdv[BIT_WR] !== 1'b0 && n < 50);
        check("write start", rdv & 32'h2, 32'h0);
    endtask
    task automatic read_word(input logic sp, input logic [14:0] a);
        wr(OFF_ADDR, 32'(a));
        wr(OFF_CTRL, sp ? 32'h41 : 32'h01);
        repeat (2) @(posedge clock);
        rd(OFF_CTRL);
        check("read start", rdv & 32'h1, 32'h0);
        rd(OFF_DLO);
        lo = rdv;
        rd(OFF_DHI);
        hi = rdv;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(56672));
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4));
            check("reset value", rdv, 32'h0);
        end
        rd(8'h40);
        check("unmapped", 32'(errv), 32'h1);
        // Start without unlock, then interrupt raise and clear
        wr(OFF_IEN, 32'h3);
        wr(OFF_CTRL, 32'h06);
        rd(OFF_CTRL);
        check("no unlock", rdv, 32'h0C);
        rd(OFF_ISTAT);
        check("error status", rdv, 32'h2);
        check("irq set", 32'(irq), 32'h1);
        wr(OFF_ICLR, 32'h3);
        repeat (2) @(posedge clock);
        check("irq clear", 32'(irq), 32'h0);
        // Broken key order, then start without enable
        wr(OFF_CTRL, 32'h04);
        wr(OFF_UNLOCK, 32'(KEY_FIRST));
        wr(OFF_UNLOCK, 32'h12);
        wr(OFF_UNLOCK, 32'(KEY_SECOND));
        wr(OFF_CTRL, 32'h06);
        rd(OFF_CTRL);
        check("bad keys", rdv, 32'h0C);
        wr(OFF_IEN, 32'h0);
        wr(OFF_CTRL, 32'h00);
        unlock();
        wr(OFF_CTRL, 32'h02);
        rd(OFF_CTRL);
        check("no enable", rdv, 32'h0);
        // EEPROM byte write and read back
        ee_a = 8'($urandom);
        ee_d = 8'($urandom);
        wr(OFF_ADDR, 32'(ee_a));
        wr(OFF_DLO, 32'(ee_d));
        unlock();
        wr(OFF_CTRL, 32'h46);
        wait_idle();
        rd(OFF_ISTAT);
        check("done status", rdv & 32'h1, 32'h1);
        wr(OFF_DLO, 32'h0);
        wr(OFF_DHI, 32'h2A);
        read_word(1'b1, 15'(ee_a));
        check("eeprom low", lo, 32'(ee_d));
        check("eeprom high", hi, 32'h2A);
        // Row erase with latch-only also set
        base = 15'($urandom_range(0, 255)) << 5;
        wr(OFF_ADDR, 32'(base + 15'd7));
        unlock();
        wr(OFF_CTRL, 32'h36);
        wait_idle();
        check("erase select", rdv & 32'h10, 32'h0);
        read_word(1'b0, base + 15'd31);
        check("erased", {hi[5:0], lo[7:0]}, 32'h3FFF);
        // Latch a whole row, commit on the last word
        for (int i = 0; i < 32; i++) begin
            row_exp[i] = 14'($urandom);
            wr(OFF_ADDR, 32'(base + 15'(i)));
            wr(OFF_DLO, 32'(row_exp[i][7:0]));
            wr(OFF_DHI, 32'(row_exp[i][13:8]));
            unlock();
            wr(OFF_CTRL, (i == 31) ? 32'h06 : 32'h26);
            wait_idle();
            if (i == 0) begin
                read_word(1'b0, base);
                check("latch only", {hi[5:0], lo[7:0]}, 32'h3FFF);
            end
        end
        wr(OFF_CTRL, 32'h00);
        for (int i = 0; i < 32; i++) begin
            read_word(1'b0, base + 15'(i));
            check("row word", {hi[5:0], lo[7:0]}, 32'(row_exp[i]));
        end
        // Reset in mid-operation
        unlock();
        wr(OFF_CTRL, 32'h06);
        warm_reset <= 1'b1;
        @(posedge clock);
        warm_reset <= 1'b0;
        rd(OFF_CTRL);
        check("aborted", rdv & 32'h0A, 32'h08);
        test_done();
    end
    // Watchdog
    initial begin
        #(50 * 30000);
        miscompares++;
        test_done();
    end
endmodule
bind nvm_program_erase_control nvm_program_erase_control_chk
    nvm_program_erase_control_chk_i (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
`default_nettype wire
